// File: txs_pkg.sv
// constants of the transmitter shaping configuration bank
package txs_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam int NREG = 11;
   localparam int IDX_W = 4;
   localparam logic [15:0] ADDR_DRIVE_SCHEME = 16'h058c;
   localparam logic [15:0] ADDR_POLARITY_PHASE = 16'h058d;
   localparam logic [15:0] ADDR_CLOCK_MODE_A = 16'h058e;
   localparam logic [15:0] ADDR_CLOCK_MODE_B = 16'h058f;
   localparam logic [15:0] ADDR_GAIN_LOW_MOD = 16'h0590;
   localparam logic [15:0] ADDR_GAIN_LOW_CW = 16'h0591;
   localparam logic [15:0] ADDR_GAIN_HIGH = 16'h0592;
   localparam logic [15:0] ADDR_ZERO_THRESHOLD = 16'h0593;
   localparam logic [15:0] ADDR_TARGET_SCALE = 16'h0594;
   localparam logic [15:0] ADDR_PHASE_QUOTIENT = 16'h0595;
   localparam logic [15:0] ADDR_PHASE_REMAINDER = 16'h0596;
   // ----------------------------------------
   // entry indices (address minus first address)
   // ----------------------------------------
   localparam int IDX_SCHEME = 0;
   localparam int IDX_POLPH = 1;
   localparam int IDX_CLKA = 2;
   localparam int IDX_CLKB = 3;
   localparam int IDX_GLMOD = 4;
   localparam int IDX_GLCW = 5;
   localparam int IDX_GHIGH = 6;
   localparam int IDX_THR = 7;
   localparam int IDX_SCALE = 8;
   localparam int IDX_PHQ = 9;
   localparam int IDX_PHR = 10;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int SCHEME_BIT = 0;
   localparam int INV_FIRST_BIT = 5;
   localparam int INV_SECOND_BIT = 4;
   localparam int PH_FIRST_BIT = 1;
   localparam int PH_SECOND_BIT = 0;
   localparam int CLK_HI_LSB = 4;
   localparam int CLK_LO_LSB = 0;
   // ----------------------------------------
   // writable bits per entry, entry 0 in the low byte
   // ----------------------------------------
   localparam logic [NREG-1:0][7:0] REG_MASK = {
      8'h0f, 8'h1f, 8'hff, 8'h7f, 8'h1f, 8'h1f,
      8'h1f, 8'h77, 8'h77, 8'h33, 8'h01};
   // ----------------------------------------
   // reset values, entry 0 in the low byte
   // ----------------------------------------
   localparam logic [NREG-1:0][7:0] REG_RESET = {
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic SCHEME_THREE_LEVEL = 1'b0;
   localparam logic SCHEME_TWO_LEVEL = 1'b1;
endpackage : txs_pkg

// File: txs_cfg_if.sv
// driver configuration carried from the bank to the shaper
`timescale 1ns/1ns
interface txs_cfg_if;
   logic twoLevel;
   logic invertFirst;
   logic invertSecond;
   logic shiftFirst;
   logic shiftSecond;
   modport bank
   (
      output twoLevel, invertFirst, invertSecond, shiftFirst, shiftSecond
   );
   modport shaper
   (
      input twoLevel, invertFirst, invertSecond, shiftFirst, shiftSecond
   );
endinterface : txs_cfg_if

// File: txs_drive_shaper.sv
// antenna driver level shaping from the carrier and the pulse gate
`timescale 1ns/1ns
module txs_drive_shaper
   import txs_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // configuration
   txs_cfg_if.shaper cfg,
   // carrier and pulse gate
   input wire logic carrierIn,
   input wire logic pulseOn,
   // driver levels
   output logic firstAntennaDriver,
   output logic secondAntennaDriver
);
   // ----------------------------------------
   // level selection
   // ----------------------------------------
   logic baseFirst;
   logic baseSecond;
   logic next_first;
   logic next_second;

   always_comb
   begin
      baseFirst = carrierIn ^ cfg.shiftFirst;
      baseSecond = carrierIn ^ cfg.shiftSecond;
      // three-level: antiphase, both at their invert level between pulses
      if (cfg.twoLevel == SCHEME_THREE_LEVEL)
         baseSecond = ~baseSecond;
      next_first = (pulseOn & baseFirst) ^ cfg.invertFirst;
      next_second = (pulseOn & baseSecond) ^ cfg.invertSecond;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         firstAntennaDriver <= 1'b0;
         secondAntennaDriver <= 1'b0;
      end
      else
      begin
         firstAntennaDriver <= next_first;
         secondAntennaDriver <= next_second;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   idle_polarity_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         !pulseOn |=> firstAntennaDriver == $past(cfg.invertFirst))
      else $error("first driver idle level differs from polarity");
   three_level_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         pulseOn && !cfg.twoLevel && cfg.shiftFirst == cfg.shiftSecond
         && cfg.invertFirst == cfg.invertSecond
         |=> firstAntennaDriver != secondAntennaDriver)
      else $error("three-level drivers not in antiphase");
   two_level_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         cfg.twoLevel && cfg.shiftFirst == cfg.shiftSecond
         && cfg.invertFirst == cfg.invertSecond
         |=> firstAntennaDriver == secondAntennaDriver)
      else $error("two-level drivers not in phase");
   phase_shift_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         pulseOn && !cfg.invertSecond && cfg.twoLevel
         |=> secondAntennaDriver
            == ($past(carrierIn) ^ $past(cfg.shiftSecond)))
      else $error("second driver phase shift wrong");
endmodule : txs_drive_shaper

// File: txs_shaping_bank.sv
// transmitter shaping configuration bank with driver shaping
// ----------------------------------------
// Summary of operation
// - eleven one-byte settings sit at consecutive addresses from 0x058c.
// - drive scheme bit 0 clear gives the three-level balanced drive.
// - drive scheme bit 0 set gives the two-level single-ended drive.
// - polarity byte bit 5 inverts the first driver when set.
// - polarity byte bit 4 inverts the second driver when set.
// - polarity byte bit 1 shifts the first carrier by half a period.
// - polarity byte bit 0 shifts the second carrier by half a period.
// - the scale byte gives a full 8-bit debug target scale.
// ----------------------------------------
//
// The strobed register port was decided locally.
`timescale 1ns/1ns
module txs_shaping_bank
   import txs_pkg::*;
#(
   parameter int AW = 16
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // register port
   input wire logic [AW-1:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdData,
   // carrier and pulse gate
   input wire logic carrierIn,
   input wire logic pulseOn,
   // antenna drivers
   output logic firstAntennaDriver,
   output logic secondAntennaDriver,
   // clock modes
   output logic [2:0] carrierClockMode,
   output logic [2:0] modulationClockMode,
   output logic [2:0] defaultClockMode,
   output logic [2:0] transitionClockMode,
   // gains and threshold
   output logic [4:0] lowSideGainModulated,
   output logic [4:0] lowSideGainCarrier,
   output logic [4:0] highSideGain,
   output logic [6:0] forceZeroThreshold,
   // scaling and phase-shift divider
   output logic [7:0] signalTargetScale,
   output logic [4:0] phaseShiftQuotient,
   output logic [3:0] phaseShiftRemainder
);
   // ----------------------------------------
   // address decode
   // ----------------------------------------
   localparam logic [AW-1:0] BASE = AW'(ADDR_DRIVE_SCHEME);
   localparam logic [AW-1:0] LAST = AW'(ADDR_PHASE_REMAINDER);

   logic [AW-1:0] offset;
   logic [IDX_W-1:0] regIdx;
   logic regHit;

   assign offset = regAddr - BASE;
   assign regIdx = offset[IDX_W-1:0];
   // only the low bits index the array, so the range test stops aliasing

   always_comb
   begin
      if (regAddr < BASE)
         regHit = 1'b0;
      else if (regAddr > LAST)
         regHit = 1'b0;
      else
         regHit = 1'b1;
   end

   // ----------------------------------------
   // storage
   // ----------------------------------------
   logic [7:0] cfgByte [NREG];

   for (genvar i = 0; i < NREG; i++)
   begin : g_entry
      always_ff @(posedge clk or negedge rst_b)
      begin
         if (!rst_b)
            cfgByte[i] <= REG_RESET[i];
         else if (regWrite && regHit && regIdx == IDX_W'(i))
            cfgByte[i] <= regWrData & REG_MASK[i];
      end

      // each entry moves only on its own write
      entry_write_a:
         assert property (@(posedge clk) disable iff (!rst_b)
            regWrite && regHit && regIdx == IDX_W'(i)
            |=> cfgByte[i] == ($past(regWrData) & REG_MASK[i]))
         else $error("entry does not hold the masked write");
      entry_hold_a:
         assert property (@(posedge clk) disable iff (!rst_b)
            !(regWrite && regHit && regIdx == IDX_W'(i))
            |=> $stable(cfgByte[i]))
         else $error("entry changed without its own write");
   end

   // ----------------------------------------
   // read port
   // ----------------------------------------
   // data only in the cycle after the strobe, zero otherwise
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         regRdData <= 8'h00;
      else if (regRead && regHit)
         regRdData <= cfgByte[regIdx];
      else
         regRdData <= 8'h00;
   end

   // ----------------------------------------
   // configuration outputs
   // ----------------------------------------
   // clock mode fields
   assign carrierClockMode = cfgByte[IDX_CLKA][CLK_HI_LSB +: 3];
   assign modulationClockMode = cfgByte[IDX_CLKA][CLK_LO_LSB +: 3];
   assign defaultClockMode = cfgByte[IDX_CLKB][CLK_HI_LSB +: 3];
   assign transitionClockMode = cfgByte[IDX_CLKB][CLK_LO_LSB +: 3];
   assign lowSideGainModulated = cfgByte[IDX_GLMOD][4:0];
   assign lowSideGainCarrier = cfgByte[IDX_GLCW][4:0];
   assign highSideGain = cfgByte[IDX_GHIGH][4:0];
   assign forceZeroThreshold = cfgByte[IDX_THR][6:0];
   assign phaseShiftQuotient = cfgByte[IDX_PHQ][4:0];
   assign phaseShiftRemainder = cfgByte[IDX_PHR][3:0];
   assign signalTargetScale = cfgByte[IDX_SCALE];

   // ----------------------------------------
   // driver shaping
   // ----------------------------------------
   txs_cfg_if cfgIf ();

   assign cfgIf.twoLevel = cfgByte[IDX_SCHEME][SCHEME_BIT];
   assign cfgIf.invertFirst = cfgByte[IDX_POLPH][INV_FIRST_BIT];
   assign cfgIf.invertSecond = cfgByte[IDX_POLPH][INV_SECOND_BIT];
   assign cfgIf.shiftFirst = cfgByte[IDX_POLPH][PH_FIRST_BIT];
   assign cfgIf.shiftSecond = cfgByte[IDX_POLPH][PH_SECOND_BIT];

   // shaper registers its outputs so the pins never glitch
   txs_drive_shaper u_shaper
   (
      .clk(clk),
      .rst_b(rst_b),
      .cfg(cfgIf.shaper),
      .carrierIn(carrierIn),
      .pulseOn(pulseOn),
      .firstAntennaDriver(firstAntennaDriver),
      .secondAntennaDriver(secondAntennaDriver)
   );

   // ----------------------------------------
   // checks
   // ----------------------------------------
   write_masked_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         regWrite && regHit ##1 regRead && $past(regAddr) == regAddr
         |=> regRdData == ($past(regWrData, 2) & REG_MASK[$past(regIdx)]))
      else $error("read-back differs from masked write");
   read_latency_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         !regRead |=> regRdData == 8'h00)
      else $error("read data outside the read cycle");
   unmapped_read_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         regRead && (regAddr < BASE || regAddr > LAST)
         |=> regRdData == 8'h00)
      else $error("unmapped address returned data");
   scheme_write_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         regWrite && regAddr == BASE
         |=> cfgIf.twoLevel == $past(regWrData[SCHEME_BIT]))
      else $error("drive scheme not taken from write");
   scale_write_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         regWrite && regAddr == AW'(ADDR_TARGET_SCALE)
         |=> signalTargetScale == $past(regWrData))
      else $error("target scale not stored whole");
   clock_mode_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         regWrite && regAddr == AW'(ADDR_CLOCK_MODE_A)
         |=> carrierClockMode == $past(regWrData[6:4])
            && modulationClockMode == $past(regWrData[2:0]))
      else $error("clock mode fields not passed");
   threshold_hold_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         !(regWrite && regAddr == AW'(ADDR_ZERO_THRESHOLD))
         |=> $stable(forceZeroThreshold))
      else $error("threshold changed without a write");
   polarity_write_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         regWrite && regAddr == AW'(ADDR_POLARITY_PHASE)
         |=> cfgIf.shiftFirst == $past(regWrData[PH_FIRST_BIT])
            && cfgIf.invertSecond == $past(regWrData[INV_SECOND_BIT]))
      else $error("polarity or phase bits not stored");

   // ----------------------------------------
   // output field checks
   // ----------------------------------------
   polarity_second_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         regWrite && regAddr == AW'(ADDR_POLARITY_PHASE)
         |=> cfgIf.invertFirst == $past(regWrData[INV_FIRST_BIT])
            && cfgIf.shiftSecond == $past(regWrData[PH_SECOND_BIT]))
      else $error("first polarity or second phase not stored");
   default_mode_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         regWrite && regAddr == AW'(ADDR_CLOCK_MODE_B)
         |=> defaultClockMode == $past(regWrData[6:4])
            && transitionClockMode == $past(regWrData[2:0]))
      else $error("second clock mode fields not passed");
   gain_modulated_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         regWrite && regAddr == AW'(ADDR_GAIN_LOW_MOD)
         |=> lowSideGainModulated == $past(regWrData[4:0]))
      else $error("modulated low-side gain not passed");
   gain_carrier_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         regWrite && regAddr == AW'(ADDR_GAIN_LOW_CW)
         |=> lowSideGainCarrier == $past(regWrData[4:0]))
      else $error("carrier low-side gain not passed");
   gain_high_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         regWrite && regAddr == AW'(ADDR_GAIN_HIGH)
         |=> highSideGain == $past(regWrData[4:0]))
      else $error("high-side gain not passed");
   threshold_write_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         regWrite && regAddr == AW'(ADDR_ZERO_THRESHOLD)
         |=> forceZeroThreshold == $past(regWrData[6:0]))
      else $error("force-zero threshold not passed");
   quotient_write_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         regWrite && regAddr == AW'(ADDR_PHASE_QUOTIENT)
         |=> phaseShiftQuotient == $past(regWrData[4:0]))
      else $error("phase divider quotient not passed");
   remainder_write_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         regWrite && regAddr == LAST
         |=> phaseShiftRemainder == $past(regWrData[3:0]))
      else $error("phase divider remainder not passed");
   scale_hold_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         !(regWrite && regAddr == AW'(ADDR_TARGET_SCALE))
         |=> $stable(signalTargetScale))
      else $error("target scale changed without a write");
   scale_read_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         regRead && regAddr == AW'(ADDR_TARGET_SCALE)
         |=> regRdData == $past(signalTargetScale))
      else $error("target scale read-back differs");
   scheme_reserved_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         regRead && regAddr == BASE |=> regRdData[7:1] == 7'h00)
      else $error("reserved scheme bits read as one");
   polarity_reserved_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         regRead && regAddr == AW'(ADDR_POLARITY_PHASE)
         |=> regRdData[7:6] == 2'b00 && regRdData[3:2] == 2'b00)
      else $error("reserved polarity bits read as one");
   unmapped_write_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         regWrite && (regAddr < BASE || regAddr > LAST)
         |=> $stable(signalTargetScale) && $stable(cfgIf.twoLevel))
      else $error("unmapped write changed a setting");
   scheme_hold_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         !(regWrite && regAddr == BASE) |=> $stable(cfgIf.twoLevel))
      else $error("drive scheme changed without a write");
   polarity_hold_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         !(regWrite && regAddr == AW'(ADDR_POLARITY_PHASE))
         |=> $stable(cfgIf.shiftFirst) && $stable(cfgIf.invertFirst))
      else $error("polarity bits changed without a write");
   threshold_read_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         regRead && regAddr == AW'(ADDR_ZERO_THRESHOLD)
         |=> regRdData == {1'b0, $past(forceZeroThreshold)})
      else $error("threshold read-back differs");
   remainder_read_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         regRead && regAddr == LAST
         |=> regRdData == {4'h0, $past(phaseShiftRemainder)})
      else $error("remainder read-back differs");
   clock_read_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         regRead && regAddr == AW'(ADDR_CLOCK_MODE_A)
         |=> regRdData == {1'b0, $past(carrierClockMode),
            1'b0, $past(modulationClockMode)})
      else $error("clock mode read-back differs");
   gain_hold_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         !(regWrite && regAddr == AW'(ADDR_GAIN_HIGH))
         |=> $stable(highSideGain))
      else $error("high-side gain changed without a write");
   divider_hold_a:
      assert property (@(posedge clk) disable iff (!rst_b)
         !(regWrite && regAddr == AW'(ADDR_PHASE_QUOTIENT))
         |=> $stable(phaseShiftQuotient))
      else $error("divider quotient changed without a write");
endmodule : txs_shaping_bank

// File: txs_driver_stage.sv
// carrier source standing in for the antenna driver stage
`timescale 1ns/1ns
module txs_driver_stage
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // control
   input wire logic runCarrier,
   // carrier to the bank
   output logic carrierIn
);
   // ----------------------------------------
   // carrier
   // ----------------------------------------
   // stands low between bursts so a stale level never looks like carrier
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         carrierIn <= 1'b0;
      else if (runCarrier)
         carrierIn <= ~carrierIn;
      else
         carrierIn <= 1'b0;
   end
endmodule : txs_driver_stage

// File: txs_shaping_bank_bench.sv
// self-checking bench for the shaping configuration bank
`timescale 1ns/1ns
module txs_shaping_bank_bench
   import txs_pkg::*;
;
   logic clk, rst_b, regWrite, regRead, pulseOn, runCarrier, carrierIn;
   logic [15:0] regAddr;
   logic [7:0] regWrData, regRdData, signalTargetScale;
   logic firstAntennaDriver, secondAntennaDriver;
   logic [2:0] carrierClockMode, modulationClockMode;
   logic [2:0] defaultClockMode, transitionClockMode;
   logic [4:0] lowSideGainModulated, lowSideGainCarrier, highSideGain;
   logic [4:0] phaseShiftQuotient;
   logic [6:0] forceZeroThreshold;
   logic [3:0] phaseShiftRemainder;
   logic [7:0] w [NREG];
   logic e1, e2;
   int mismatches = 0;
   int n_compared = 0;
   // ----------------------------------------
   // instances
   // ----------------------------------------
   txs_shaping_bank i_dut (.clk(clk), .rst_b(rst_b), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData), .carrierIn(carrierIn), .pulseOn(pulseOn),
      .firstAntennaDriver(firstAntennaDriver),
      .secondAntennaDriver(secondAntennaDriver),
      .carrierClockMode(carrierClockMode),
      .modulationClockMode(modulationClockMode),
      .defaultClockMode(defaultClockMode),
      .transitionClockMode(transitionClockMode),
      .lowSideGainModulated(lowSideGainModulated),
      .lowSideGainCarrier(lowSideGainCarrier), .highSideGain(highSideGain),
      .forceZeroThreshold(forceZeroThreshold),
      .signalTargetScale(signalTargetScale),
      .phaseShiftQuotient(phaseShiftQuotient),
      .phaseShiftRemainder(phaseShiftRemainder));
   txs_driver_stage i_stage (.clk(clk), .rst_b(rst_b),
      .runCarrier(runCarrier), .carrierIn(carrierIn));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         mismatches++;
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      @(negedge clk);
      chk(regRdData, exp);
   endtask : rd
   // write then read back with no idle cycle between the strobes
   task automatic wrrd(input logic [15:0] a, input logic [7:0] d,
      input logic [7:0] exp);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      @(negedge clk);
      chk(regRdData, exp);
   endtask : wrrd
   task automatic summarize;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize
   // ----------------------------------------
   // clock and watchdog
   // ----------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      mismatches++;
      summarize();
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial
   begin
      rst_b = 1'b0;
      {regWrite, regRead, pulseOn, runCarrier} = 4'h0;
      regAddr = 16'h0000;
      regWrData = 8'h00;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < NREG; i++)
         rd(16'(ADDR_DRIVE_SCHEME + i), 8'h00);
      $display("test reset values done");
      for (int p = 0; p < 2; p++)
      begin
         for (int i = 0; i < NREG; i++)
         begin
            w[i] = (p == 0 ? 8'ha5 : 8'h5a) ^ 8'(i);
            wr(16'(ADDR_DRIVE_SCHEME + i), w[i]);
         end
         for (int i = 0; i < NREG; i++)
            rd(16'(ADDR_DRIVE_SCHEME + i), w[i] & REG_MASK[i]);
         chk(8'(carrierClockMode), 8'(w[2][6:4]));
         chk(8'(modulationClockMode), 8'(w[2][2:0]));
         chk(8'(defaultClockMode), 8'(w[3][6:4]));
         chk(8'(transitionClockMode), 8'(w[3][2:0]));
         chk(8'(lowSideGainModulated), 8'(w[4][4:0]));
         chk(8'(lowSideGainCarrier), 8'(w[5][4:0]));
         chk(8'(highSideGain), 8'(w[6][4:0]));
         chk(8'(forceZeroThreshold), 8'(w[7][6:0]));
         chk(signalTargetScale, w[8]);
         chk(8'(phaseShiftQuotient), 8'(w[9][4:0]));
         chk(8'(phaseShiftRemainder), 8'(w[10][3:0]));
      end
      $display("test field pass-through done");
      // unmapped neighbours on both sides must not alias the bank
      wr(16'h058b, 8'hff);
      wr(16'h0597, 8'hff);
      // low bits of this one alias the first entry
      wr(16'h059c, 8'hff);
      rd(16'h058b, 8'h00);
      rd(16'h059c, 8'h00);
      rd(16'h0597, 8'h00);
      rd(ADDR_DRIVE_SCHEME, w[0] & 8'h01);
      $display("test unmapped done");
      for (int i = 0; i < NREG; i++)
         wrrd(16'(ADDR_DRIVE_SCHEME + i), 8'hff, REG_MASK[i]);
      $display("test back-to-back done");
      runCarrier <= 1'b1;
      for (int s = 0; s < 2; s++)
         for (int k = 0; k < 16; k++)
         begin
            // reserved bits set throughout, they must steer nothing
            wr(ADDR_DRIVE_SCHEME, {7'h7f, s[0]});
            wr(ADDR_POLARITY_PHASE, {2'b11, k[3:2], 2'b11, k[1:0]});
            for (int c = 0; c < 8; c++)
            begin
               @(posedge clk);
               pulseOn <= c[1];
               @(negedge clk);
               if (c > 0)
                  chk({6'h0, firstAntennaDriver, secondAntennaDriver},
                     {6'h0, e1, e2});
               e1 = (pulseOn & (carrierIn ^ k[1])) ^ k[3];
               e2 = (pulseOn & (carrierIn ^ k[0] ^ ~s[0])) ^ k[2];
            end
         end
      runCarrier <= 1'b0;
      $display("test driver shaping done");
      summarize();
   end
endmodule : txs_shaping_bank_bench
